/* drive_status_pkg.sv */
/*
  Constants, encodings and types shared by the drive status register logic.
  Assumes a single drive logic clock; command codes arrive as a five bit
  function field.
*/
package drive_status_pkg;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int unsigned STATUS_W     = 16;
  localparam int unsigned HL_W         = 6;
  localparam int unsigned BIT_HL_LO    = 0;
  localparam int unsigned BIT_HL_HI    = 5;
  localparam int unsigned BIT_SLOW     = 0;
  localparam int unsigned BIT_FAST     = 1;
  localparam int unsigned BIT_GUARD    = 2;
  localparam int unsigned BIT_REVERSE  = 3;
  localparam int unsigned BIT_BELOW    = 4;
  localparam int unsigned BIT_ONE      = 5;
  localparam int unsigned BIT_VV       = 6;
  localparam int unsigned BIT_DRY      = 7;
  localparam int unsigned BIT_DPR      = 8;
  localparam int unsigned BIT_PGM      = 9;
  localparam int unsigned BIT_LST      = 10;
  localparam int unsigned BIT_WRL      = 11;
  localparam int unsigned BIT_MOL      = 12;
  localparam int unsigned BIT_PIP      = 13;
  localparam int unsigned BIT_ERR      = 14;
  localparam int unsigned BIT_ATA      = 15;

  localparam logic [STATUS_W-1:0] STATUS_ZERO = 16'h0000;
  localparam logic [HL_W-1:0]     HL_CLEAR    = 6'h00;
  localparam logic                DRY_RESET   = 1'b1;

  // ----------------------------------------------------------------
  // Difference counter limits
  // ----------------------------------------------------------------
  localparam int unsigned   DIFF_W     = 8;
  localparam logic [7:0]    DIFF_LIMIT = 8'h40;
  localparam logic [7:0]    DIFF_ONE   = 8'h01;

  // ----------------------------------------------------------------
  // Controller select switch and identities
  // ----------------------------------------------------------------
  localparam logic [1:0] SW_NEUTRAL = 2'h0;
  localparam logic       CTRL_A     = 1'b0;
  localparam logic       CTRL_B     = 1'b1;

  // ----------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------
  localparam logic [4:0] FN_NOP      = 5'h00;
  localparam logic [4:0] FN_UNLOAD   = 5'h01;
  localparam logic [4:0] FN_SEEK     = 5'h02;
  localparam logic [4:0] FN_RECAL    = 5'h03;
  localparam logic [4:0] FN_DCLR     = 5'h04;
  localparam logic [4:0] FN_RELEASE  = 5'h05;
  localparam logic [4:0] FN_OFFSET   = 5'h06;
  localparam logic [4:0] FN_CENTER   = 5'h07;
  localparam logic [4:0] FN_PRESET   = 5'h08;
  localparam logic [4:0] FN_PACK_ACK = 5'h09;
  localparam logic [4:0] FN_SEARCH   = 5'h0C;

  typedef enum logic [1:0] {
    CLS_READY,
    CLS_POSITION,
    CLS_OTHER
  } cmd_class_t;

  typedef enum logic {
    EX_IDLE,
    EX_RUN
  } exec_t;

endpackage

/* cmd_class_decode.sv */
/*
  Function code classifier for the drive status logic.
  Purely combinational; the caller samples the outputs with its start strobe.
*/
module cmd_class_decode (
  input  wire logic [4:0]                    code,
  output drive_status_pkg::cmd_class_t       cls,
  output logic                               is_unload,
  output logic                               is_drive_clear,
  output logic                               is_volume_set
);

  always_comb
  begin
    is_unload      = (code == drive_status_pkg::FN_UNLOAD);
    is_drive_clear = (code == drive_status_pkg::FN_DCLR);
    is_volume_set  = (code == drive_status_pkg::FN_PACK_ACK) ||
                     (code == drive_status_pkg::FN_PRESET);
    unique case (code)
      drive_status_pkg::FN_NOP,
      drive_status_pkg::FN_DCLR,
      drive_status_pkg::FN_PACK_ACK,
      drive_status_pkg::FN_PRESET:
        cls = drive_status_pkg::CLS_READY;
      drive_status_pkg::FN_UNLOAD,
      drive_status_pkg::FN_RECAL,
      drive_status_pkg::FN_SEARCH,
      drive_status_pkg::FN_SEEK,
      drive_status_pkg::FN_OFFSET,
      drive_status_pkg::FN_CENTER:
        cls = drive_status_pkg::CLS_POSITION;
      // Transfers, release and illegal codes
      default:
        cls = drive_status_pkg::CLS_OTHER;
    endcase
  end

endmodule

/* drive_status_register.sv */
/*
  Drive status register of a moving-head disk drive's control logic:
  head-load monitor bits, volume valid per controller, ready, present,
  programmable, last sector, write lock, medium on-line, positioning,
  composite error and attention, plus the attention line.
  Assumes all inputs are synchronous to sys_clk, events are one-cycle
  pulses, and sys_rst stands for the initialize line at power-on.
*/
module drive_status_register (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     drive_init,
  input  wire logic                     head_load_mode,
  input  wire logic                     start_pulse,
  input  wire logic                     slow_forward_seen,
  input  wire logic                     fast_forward_seen,
  input  wire logic                     inner_guard_band_seen,
  input  wire logic                     go_reverse_seen,
  input  wire logic                     reverse_seek,
  input  wire logic [7:0]               diff_count,
  input  wire logic                     file_ready,
  input  wire logic                     power_up_done,
  input  wire logic [1:0]               ctrl_switch,
  input  wire logic                     spindle_down,
  input  wire logic                     off_line,
  input  wire logic                     write_protect_sw,
  input  wire logic                     write_req,
  input  wire logic                     last_sector,
  input  wire logic                     err_any,
  input  wire logic                     data_transfer,
  input  wire logic                     cmd_start,
  input  wire logic [4:0]               cmd_code,
  input  wire logic                     cmd_ctrl,
  input  wire logic                     cmd_done,
  input  wire logic                     dual_mode,
  input  wire logic                     owner,
  input  wire logic                     other_request,
  input  wire logic                     attn_clear,
  input  wire logic                     status_rd,
  input  wire logic                     reader,
  output logic [15:0]                   status_data,
  output logic                          status_valid,
  output logic                          attention,
  output logic                          write_allowed
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    drive_status_pkg::exec_t      exec;
    drive_status_pkg::cmd_class_t cls;
    logic                         unload_run;
    logic                         armed;
    logic [5:0]                   hl;
    logic                         vv_a;
    logic                         vv_b;
    logic                         drive_ready;
    logic                         positioning_in_progress;
    logic                         programmable_select;
    logic                         last_sector_done;
    logic                         medium_on_line;
    logic                         err;
    logic                         err_prev;
    logic                         attention_active;
    logic                         pend_a;
    logic                         pend_b;
    logic [15:0]                  rd_data;
    logic                         rd_valid;
  } state_t;

  state_t st;
  state_t next_st;

  drive_status_pkg::cmd_class_t dec_cls;
  logic                         dec_unload;
  logic                         dec_dclr;
  logic                         dec_vol;

  cmd_class_decode u_decode (
    .code           (cmd_code),
    .cls            (dec_cls),
    .is_unload      (dec_unload),
    .is_drive_clear (dec_dclr),
    .is_volume_set  (dec_vol)
  );

  logic [5:0]  hl_set;
  logic        dclr_evt;
  logic        pos_done;
  logic        err_evt;
  logic        avail_evt;
  logic        mol_change;
  logic        ata_set;
  logic        ata_clr;
  logic [15:0] word;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st          = st;
    next_st.rd_valid = 1'b0;
    hl_set = drive_status_pkg::HL_CLEAR;
    hl_set[drive_status_pkg::BIT_SLOW]    = head_load_mode && st.armed && slow_forward_seen;
    hl_set[drive_status_pkg::BIT_FAST]    = head_load_mode && fast_forward_seen;
    hl_set[drive_status_pkg::BIT_GUARD]   = head_load_mode && inner_guard_band_seen;
    hl_set[drive_status_pkg::BIT_REVERSE] = head_load_mode && go_reverse_seen;
    hl_set[drive_status_pkg::BIT_BELOW]   = head_load_mode && reverse_seek &&
                                            (diff_count < drive_status_pkg::DIFF_LIMIT);
    hl_set[drive_status_pkg::BIT_ONE]     = head_load_mode &&
                                            (diff_count == drive_status_pkg::DIFF_ONE);
    if (head_load_mode && start_pulse)
      next_st.armed = 1'b1;
    if (file_ready)
    begin
      // Completed load wipes the fault record; a same-cycle detection survives
      next_st.hl    = hl_set;
      next_st.armed = 1'b0;
    end
    else
    begin
      next_st.hl = st.hl | hl_set;
    end
    // Medium on-line, set beats clear
    if (file_ready)
      next_st.medium_on_line = 1'b1;
    else if (spindle_down || off_line)
      next_st.medium_on_line = 1'b0;
    mol_change = (next_st.medium_on_line != st.medium_on_line);
    // Programmable bit and volume valid at cycle up
    if (power_up_done)
    begin
      next_st.programmable_select  = (ctrl_switch == drive_status_pkg::SW_NEUTRAL);
      next_st.vv_a = 1'b0;
      next_st.vv_b = 1'b0;
    end
    // Command execution; the controller only starts when ready
    dclr_evt = 1'b0;
    pos_done = 1'b0;
    if (cmd_start)
    begin
      next_st.cls        = dec_cls;
      next_st.unload_run = dec_unload;
      dclr_evt           = dec_dclr;
      if (dec_vol)
      begin
        if (cmd_ctrl == drive_status_pkg::CTRL_A)
          next_st.vv_a = 1'b1;
        else
          next_st.vv_b = 1'b1;
      end
      unique case (dec_cls)
        drive_status_pkg::CLS_READY:
        begin
          // Finishes at once, ready never drops
          next_st.exec = drive_status_pkg::EX_IDLE;
          next_st.drive_ready  = 1'b1;
          next_st.positioning_in_progress  = 1'b0;
        end
        drive_status_pkg::CLS_POSITION:
        begin
          next_st.exec = drive_status_pkg::EX_RUN;
          next_st.drive_ready  = 1'b0;
          next_st.positioning_in_progress  = 1'b1;
        end
        drive_status_pkg::CLS_OTHER:
        begin
          next_st.exec = drive_status_pkg::EX_RUN;
          next_st.drive_ready  = 1'b0;
          next_st.positioning_in_progress  = 1'b0;
        end
      endcase
    end
    else if (cmd_done && (st.exec == drive_status_pkg::EX_RUN))
    begin
      next_st.exec       = drive_status_pkg::EX_IDLE;
      next_st.drive_ready        = 1'b1;
      next_st.positioning_in_progress        = 1'b0;
      next_st.unload_run = 1'b0;
      pos_done           = (st.cls == drive_status_pkg::CLS_POSITION);
    end
    // Set beats initialize, and drive clear for the error bit
    next_st.last_sector_done = last_sector || (st.last_sector_done && !drive_init);
    next_st.err      = err_any || (st.err && !(dclr_evt || drive_init));
    next_st.err_prev = err_any;
    err_evt          = err_any && !st.err_prev && !data_transfer;
    // Availability to a controller that asked while the drive was held
    avail_evt = 1'b0;
    if (dual_mode && other_request)
    begin
      if (owner != drive_status_pkg::CTRL_A)
        next_st.pend_a = 1'b1;
      if (owner != drive_status_pkg::CTRL_B)
        next_st.pend_b = 1'b1;
    end
    if (st.pend_a && (owner == drive_status_pkg::CTRL_A))
    begin
      next_st.pend_a = 1'b0;
      avail_evt      = dual_mode;
    end
    if (st.pend_b && (owner == drive_status_pkg::CTRL_B))
    begin
      next_st.pend_b = 1'b0;
      avail_evt      = dual_mode;
    end
    // Attention: only drive events set it, set beats clear
    ata_set     = pos_done || err_evt || avail_evt || (mol_change && !st.unload_run);
    ata_clr     = dclr_evt || attn_clear || drive_init;
    next_st.attention_active = ata_set || (st.attention_active && !ata_clr);
    // Status word as seen by the reading controller
    word = drive_status_pkg::STATUS_ZERO;
    word[drive_status_pkg::BIT_HL_HI:drive_status_pkg::BIT_HL_LO] = st.hl;
    word[drive_status_pkg::BIT_VV]  = (reader == drive_status_pkg::CTRL_A) ? st.vv_a
                                                                           : st.vv_b;
    word[drive_status_pkg::BIT_DRY] = st.drive_ready;
    word[drive_status_pkg::BIT_DPR] = !dual_mode || (reader == owner);
    word[drive_status_pkg::BIT_PGM] = st.programmable_select;
    word[drive_status_pkg::BIT_LST] = st.last_sector_done;
    word[drive_status_pkg::BIT_WRL] = write_protect_sw;
    word[drive_status_pkg::BIT_MOL] = st.medium_on_line;
    word[drive_status_pkg::BIT_PIP] = st.positioning_in_progress;
    word[drive_status_pkg::BIT_ERR] = st.err;
    word[drive_status_pkg::BIT_ATA] = st.attention_active;
    // Read path only; no write path exists, so writes vanish silently
    if (status_rd)
    begin
      next_st.rd_valid = 1'b1;
      next_st.rd_data  = (dual_mode && (reader != owner)) ? drive_status_pkg::STATUS_ZERO
                                                           : word;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st      <= '0;
      st.exec <= drive_status_pkg::EX_IDLE;
      st.cls  <= drive_status_pkg::CLS_READY;
      st.drive_ready  <= drive_status_pkg::DRY_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign status_data   = st.rd_data;
  assign status_valid  = st.rd_valid;
  assign attention     = st.attention_active;
  // Write gate is combinational so a protected drive never starts a write
  assign write_allowed = write_req && !write_protect_sw;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  property p_hl_clear;
    file_ready && !head_load_mode |=> (st.hl == drive_status_pkg::HL_CLEAR);
  endproperty
  a_hl_clear: assert property (p_hl_clear) else $error("load bits kept after ready");
  sequence s_armed_slow;
    head_load_mode && start_pulse && !file_ready ##1 !file_ready ##1
      head_load_mode && slow_forward_seen && !file_ready;
  endsequence
  property p_slow;
    s_armed_slow |=> st.hl[drive_status_pkg::BIT_SLOW];
  endproperty
  a_slow: assert property (p_slow) else $error("slow forward not recorded");
  property p_guard;
    head_load_mode && inner_guard_band_seen |=> st.hl[drive_status_pkg::BIT_GUARD];
  endproperty
  a_guard: assert property (p_guard) else $error("guard band not recorded");
  property p_below;
    head_load_mode && reverse_seek && (diff_count == drive_status_pkg::DIFF_LIMIT - 8'h01) |=>
      st.hl[drive_status_pkg::BIT_BELOW];
  endproperty
  a_below: assert property (p_below) else $error("below limit not recorded");
  property p_not_below;
    !st.hl[drive_status_pkg::BIT_BELOW] && (diff_count == drive_status_pkg::DIFF_LIMIT) |=>
      !st.hl[drive_status_pkg::BIT_BELOW];
  endproperty
  a_not_below: assert property (p_not_below) else $error("limit bit set at 64");
  property p_vv_sep;
    cmd_start && dec_vol && (cmd_ctrl == drive_status_pkg::CTRL_A) && !power_up_done |=>
      st.vv_a && $stable(st.vv_b);
  endproperty
  a_vv_sep: assert property (p_vv_sep) else $error("volume valid copy crossed");
  property p_vv_clear;
    power_up_done && !cmd_start |=> !st.vv_a && !st.vv_b;
  endproperty
  a_vv_clear: assert property (p_vv_clear) else $error("volume valid survived cycle up");
  sequence s_pos_end;
    (st.exec == drive_status_pkg::EX_RUN) && (st.cls == drive_status_pkg::CLS_POSITION) &&
      cmd_done && !cmd_start;
  endsequence
  property p_pos_end;
    s_pos_end |=> st.attention_active && st.drive_ready && !st.positioning_in_progress;
  endproperty
  a_pos_end: assert property (p_pos_end) else $error("movement end flags wrong");
  property p_cls;
    cmd_start && (dec_cls == drive_status_pkg::CLS_POSITION) |=> !st.drive_ready && st.positioning_in_progress;
  endproperty
  a_cls: assert property (p_cls) else $error("positioning class flags wrong");
  property p_zero_read;
    status_rd && dual_mode && (reader != owner) |=>
      status_valid && (status_data == drive_status_pkg::STATUS_ZERO);
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("non-owner saw status");
  property p_err_hold;
    st.err && !drive_init && !(cmd_start && dec_dclr) |=> st.err;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("composite error lost");
  property p_mol_ata;
    (st.medium_on_line != $past(st.medium_on_line)) && !$past(st.unload_run) |-> st.attention_active;
  endproperty
  a_mol_ata: assert property (p_mol_ata) else $error("on-line change without attention");
  property p_ata_clear;
    attn_clear && !file_ready && !err_any && !cmd_done && !other_request &&
      !spindle_down && !off_line && !st.pend_a && !st.pend_b |=> !attention;
  endproperty
  a_ata_clear: assert property (p_ata_clear) else $error("attention not cleared");
  property p_wrl;
    write_protect_sw |-> !write_allowed;
  endproperty
  a_wrl: assert property (p_wrl) else $error("write allowed while protected");
endmodule

/* ctrl_model.sv */
/*
  Controller model: issues commands, status reads and attention clears.
  Assumes one bench process calls its tasks, inputs driven 1 ns past the edge.
*/
module ctrl_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] status_data,
  input  wire logic        status_valid,
  output logic             cmd_start,
  output logic [4:0]       cmd_code,
  output logic             cmd_ctrl,
  output logic             status_rd,
  output logic             reader,
  output logic             attn_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cmd_start, cmd_code, cmd_ctrl, status_rd, reader, attn_clear} = '0;
  // Callers only start a command while ready reads one
  task automatic cmd(input logic [4:0] c, input logic k);
    @(posedge sys_clk);
    #1 cmd_start = 1'b1;
    cmd_code = c;
    cmd_ctrl = k;
    @(posedge sys_clk);
    #1 cmd_start = 1'b0;
  endtask
  // A late or missing answer returns unknowns so it can never match
  task automatic rd(input logic r, output logic [15:0] d);
    @(posedge sys_clk);
    #1 status_rd = 1'b1;
    reader = r;
    @(posedge sys_clk);
    #1 status_rd = 1'b0;
    d = status_valid ? status_data : 16'hXXXX;
  endtask
  task automatic clr();
    @(posedge sys_clk);
    #1 attn_clear = 1'b1;
    @(posedge sys_clk);
    #1 attn_clear = 1'b0;
  endtask
endmodule

/* test_drive_status_register.sv */
/*
  Self-checking bench for the drive status register.
  Assumes ctrl_model plays the controllers; events are one-cycle pulses.
*/
module test_drive_status_register;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, sys_rst, head_load_mode, reverse_seek, write_protect_sw, write_req;
  logic        err_any, data_transfer, dual_mode, owner;
  logic [7:0]  diff_count;
  logic [1:0]  ctrl_switch;
  logic [12:0] ev;
  logic [15:0] status_data, base;
  logic [4:0]  cmd_code;
  logic        status_valid, attention, write_allowed, cmd_start, cmd_ctrl, status_rd;
  logic        reader, attn_clear;
  int          bad_count, cmp_count;
  logic [4:0]  codes [12] = '{5'h00, 5'h04, 5'h08, 5'h09, 5'h01, 5'h02, 5'h03, 5'h06,
                             5'h07, 5'h0C, 5'h05, 5'h18};
  drive_status_register drive_status_register_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .drive_init(ev[12]), .head_load_mode(head_load_mode), .start_pulse(ev[0]),
    .slow_forward_seen(ev[1]), .fast_forward_seen(ev[2]), .inner_guard_band_seen(ev[3]),
    .go_reverse_seen(ev[4]), .reverse_seek(reverse_seek), .diff_count(diff_count),
    .file_ready(ev[5]), .power_up_done(ev[6]), .ctrl_switch(ctrl_switch),
    .spindle_down(ev[7]), .off_line(ev[8]), .write_protect_sw(write_protect_sw),
    .write_req(write_req), .last_sector(ev[9]), .err_any(err_any),
    .data_transfer(data_transfer), .cmd_start(cmd_start), .cmd_code(cmd_code),
    .cmd_ctrl(cmd_ctrl), .cmd_done(ev[10]), .dual_mode(dual_mode), .owner(owner),
    .other_request(ev[11]), .attn_clear(attn_clear), .status_rd(status_rd),
    .reader(reader), .status_data(status_data), .status_valid(status_valid),
    .attention(attention), .write_allowed(write_allowed));
  ctrl_model ctrl_model_i (.sys_clk(sys_clk), .status_data(status_data),
    .status_valid(status_valid), .cmd_start(cmd_start), .cmd_code(cmd_code),
    .cmd_ctrl(cmd_ctrl), .status_rd(status_rd), .reader(reader), .attn_clear(attn_clear));
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rdc(input logic r, input logic [15:0] e);
    logic [15:0] d;
    ctrl_model_i.rd(r, d);
    chk(d, e);
  endtask
  task automatic pulse(input logic [12:0] m);
    @(posedge sys_clk);
    #1 ev = m;
    @(posedge sys_clk);
    #1 ev = '0;
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #20000 bad_count++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    {head_load_mode, reverse_seek, write_protect_sw, write_req, err_any} = '0;
    {data_transfer, dual_mode, owner, diff_count, ctrl_switch, ev} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    rdc(1'b0, 16'h0180);
    pulse(13'h0040);
    rdc(1'b0, 16'h0380);
    head_load_mode = 1'b1;
    reverse_seek = 1'b1;
    diff_count = 8'h40;
    pulse(13'h0001);
    rdc(1'b0, 16'h0380);
    diff_count = 8'h3F;
    pulse(13'h001E);
    diff_count = 8'h01;
    rdc(1'b0, 16'h03BF);
    {head_load_mode, reverse_seek, diff_count} = {2'b00, 8'h80};
    pulse(13'h0020);
    rdc(1'b0, 16'h9380);
    ctrl_model_i.clr();
    base = 16'h1380;
    for (int i = 0; i < 12; i++)
    begin
      if (codes[i] == 5'h08 || codes[i] == 5'h09)
        base = base | 16'h0040;
      ctrl_model_i.cmd(codes[i], 1'b0);
      if (codes[i] inside {5'h00, 5'h04, 5'h08, 5'h09})
        rdc(1'b0, base);
      else
      begin
        if (codes[i] inside {5'h05, 5'h18})
          rdc(1'b0, base & 16'hFF7F);
        else
          rdc(1'b0, (base & 16'hFF7F) | 16'h2000);
        pulse(13'h0400);
        rdc(1'b0, base | (codes[i] inside {5'h05, 5'h18} ? 16'h0000 : 16'h8000));
        ctrl_model_i.clr();
      end
    end
    rdc(1'b1, 16'h1380);
    {dual_mode, owner} = 2'b10;
    rdc(1'b1, 16'h0000);
    rdc(1'b0, 16'h13C0);
    pulse(13'h0800);
    owner = 1'b1;
    pulse(13'h0000);
    rdc(1'b1, 16'h9380);
    {dual_mode, owner} = 2'b00;
    pulse(13'h0000);
    ctrl_model_i.clr();
    {data_transfer, err_any} = 2'b11;
    rdc(1'b0, 16'h53C0);
    {data_transfer, err_any} = 2'b00;
    ctrl_model_i.cmd(5'h04, 1'b0);
    rdc(1'b0, 16'h13C0);
    err_any = 1'b1;
    pulse(13'h0200);
    err_any = 1'b0;
    rdc(1'b0, 16'hD7C0);
    chk({15'h0000, attention}, 16'h0001);
    pulse(13'h1000);
    rdc(1'b0, 16'h13C0);
    {write_protect_sw, write_req} = 2'b11;
    rdc(1'b0, 16'h1BC0);
    chk({15'h0000, write_allowed}, 16'h0000);
    write_protect_sw = 1'b0;
    pulse(13'h0100);
    chk({15'h0000, write_allowed}, 16'h0001);
    rdc(1'b0, 16'h83C0);
    ctrl_switch = 2'h1;
    pulse(13'h0040);
    rdc(1'b0, 16'h8180);
    ctrl_model_i.cmd(5'h09, 1'b1);
    rdc(1'b1, 16'h81C0);
    rdc(1'b0, 16'h8180);
    report_and_stop();
  end
endmodule
